//--- hdl/lsd_consts.svh
// named constants of the lcd segment driver host port
`ifndef LSD_CONSTS_SVH
`define LSD_CONSTS_SVH

// display geometry
`define LSD_NCOL       64
`define LSD_COL_W      6
`define LSD_PAGE_W     3
`define LSD_LINE_W     6
`define LSD_RAM_AW     9

// instruction opcode fields and their values
`define LSD_F_ONOFF    7:1
`define LSD_OPC_ONOFF  7'h1f
`define LSD_B_ONOFF    0
`define LSD_F_TOP2     7:6
`define LSD_OPC_ADDR   2'h1
`define LSD_OPC_LINE   2'h3
`define LSD_F_PAGEOP   7:3
`define LSD_OPC_PAGE   5'h17
`define LSD_F_COLARG   5:0
`define LSD_F_PAGEARG  2:0
`define LSD_F_LINEARG  5:0

// line counter split into page and row within page
`define LSD_F_LPAGE    5:3
`define LSD_F_LROW     2:0

// status byte bit positions
`define LSD_ST_BUSY    7
`define LSD_ST_ONOFF   5
`define LSD_ST_RESET   4

// reset values
`define LSD_COL_RST    6'h00
`define LSD_PAGE_RST   3'h0
`define LSD_LINE_RST   6'h00
`define LSD_DB_RST     8'h00

`endif

//--- hdl/lsd_host_port.sv
// lcd segment driver: host parallel port, display memory control and segment latch
// What this block does
// [RQ1] unselected chip ignores every access
// [RQ2] reset pin and column order ignore selects
// [RQ3] write byte captured at strobe fall, stored
// [RQ4] host reads data twice, first is dummy
// [RQ5] status read needs no dummy read
// [RQ6] select and read line decode access type
// [RQ7] reset pin: display off, start line zero
// [RQ8] reset status shown on bit four
// [RQ9] busy flag shown on bit seven
// [RQ10] display on/off state shown on bit five
// [RQ11] display off or reset blanks segments
// [RQ12] on/off change applied at line latch
// [RQ13] page register changes only by instruction
// [RQ14] column counter loads and steps per access
// [RQ15] memory bit one lights the dot
// [RQ16] column order strap reverses segment mapping
// [RQ17] frame sync presets line counter from start
// [RQ18] on/off instruction lowest bit selects state
// [RQ19] set-address loads six-bit column
// [RQ20] set-page loads three-bit page
// [RQ21] start line instruction loads six-bit line
// [RQ22] host selects with both lows, high
// [RQ23] read data driven only while strobe high
// [RQ24] row latched on strobe rise, advance fall
// [RQ25] six-bit line counter preset by frame
// [RQ26] memory is eight pages by sixty-four
// [RQ27] column wraps to zero, page unchanged
`include "lsd_consts.svh"
module lsd_host_port
   import lsd_pkg::*;
#(
   parameter int FIFO_DEPTH = 2
) (
   // clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_resetn,
   // host port pins
   input  wire logic                   i_chip_sel_low_a_n,
   input  wire logic                   i_chip_sel_low_b_n,
   input  wire logic                   i_chip_sel_high,
   input  wire logic                   i_strobe,
   input  wire logic                   i_read_not_write,
   input  wire logic                   i_data_instr_select,
   input  wire logic [7:0]             i_db,
   output logic      [7:0]             o_db,
   output logic                        o_db_oe_n,
   output logic                        o_cmd_ready,
   // reset pin and strap
   input  wire logic                   i_reset_n_pin,
   input  wire logic                   i_col_order,
   // display timing
   input  wire logic                   i_phase_one_clock,
   input  wire logic                   i_phase_two_clock,
   input  wire logic                   i_frame_sync,
   input  wire logic                   i_line_latch_strobe,
   output logic      [`LSD_NCOL-1:0]   o_seg,
   output logic      [`LSD_LINE_W-1:0] o_line
);

   localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FIFO_DEPTH must be a power of two and at least 2");
   end

   lsd_pins_s                pin_raw;
   lsd_pins_s                s1;
   lsd_pins_s                s2;
   lsd_pins_s                s3;
   lsd_pins_s                pf;
   lsd_pins_s                pq;
   logic                     sel;
   logic                     sel_q;
   logic                     strobe_fall;
   logic                     p1_rise;
   logic                     p2_rise;
   logic                     cl_rise;
   logic                     cl_fall;
   logic                     rst_pin;
   logic                     acc_instr;
   logic                     acc_wr;
   logic                     acc_rd;
   logic                     push_valid;
   logic                     push_ready;
   logic                     pop_valid;
   logic                     pop_ready;
   logic                     stat_rd;
   lsd_cmd_s                 in_cmd;
   lsd_cmd_s                 head;
   lsd_cmd_s                 fifo_mem [FIFO_DEPTH];
   logic [PW-1:0]            wr_ptr;
   logic [PW-1:0]            rd_ptr;
   logic [PW:0]              cnt;
   lsd_exec_e                exec_st;
   logic                     instr_do;
   logic                     data_do;
   logic                     ram_we;
   logic [7:0]               rdata_a;
   logic [7:0]               rdata_b;
   logic [7:0]               out_reg;
   logic [7:0]               status;
   logic [`LSD_PAGE_W-1:0]   page;
   logic [`LSD_COL_W-1:0]    col;
   logic [`LSD_LINE_W-1:0]   start_line;
   logic                     disp_on;
   logic                     disp_shown;
   logic [`LSD_LINE_W-1:0]   line;
   logic [`LSD_LINE_W-1:0]   fetched_line;
   lsd_scan_e                scan_st;
   logic [`LSD_COL_W-1:0]    scan_col;
   logic [`LSD_COL_W-1:0]    scan_col_q;
   logic                     scan_rd_q;
   logic [`LSD_COL_W-1:0]    seg_idx;
   logic [`LSD_NCOL-1:0]     shadow;
   logic [`LSD_NCOL-1:0]     seg_latch;

   // every pin is foreign to i_clk: three flops, accept when stages two and three agree
   assign pin_raw = '{db: i_db, strobe: i_strobe, rd: i_read_not_write,
                      rs: i_data_instr_select, cs_a_n: i_chip_sel_low_a_n,
                      cs_b_n: i_chip_sel_low_b_n, cs_h: i_chip_sel_high,
                      rst_n: i_reset_n_pin, col_order: i_col_order,
                      frame: i_frame_sync, cl: i_line_latch_strobe,
                      p1: i_phase_one_clock, p2: i_phase_two_clock};

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= pin_raw;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // filtered pin view and its previous value for edge detection
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         pf <= '0;
         pq <= '0;
      end else begin
         pf <= lsd_pins_s'((s2 & s3) | (pf & ~(s2 ^ s3)));
         pq <= pf;
      end
   end

   assign sel         = !pf.cs_a_n && !pf.cs_b_n && pf.cs_h;  // RQ1
   assign sel_q       = !pq.cs_a_n && !pq.cs_b_n && pq.cs_h;
   assign strobe_fall = pq.strobe && !pf.strobe;
   assign p1_rise     = !pq.p1 && pf.p1;
   assign p2_rise     = !pq.p2 && pf.p2;
   assign cl_rise     = !pq.cl && pf.cl;  // RQ24
   assign cl_fall     = pq.cl && !pf.cl;  // RQ24
   assign rst_pin     = !pf.rst_n;

   // access decode at the strobe fall; the reset pin locks out all but status reads
   assign acc_instr  = strobe_fall && sel_q && !pq.rs && !pq.rd && !rst_pin;  // RQ6
   assign acc_wr     = strobe_fall && sel_q && pq.rs && !pq.rd && !rst_pin;  // RQ6
   assign acc_rd     = strobe_fall && sel_q && pq.rs && pq.rd && !rst_pin;  // RQ6
   assign stat_rd    = sel && pf.strobe && pf.rd && !pf.rs;  // RQ5
   assign push_valid = acc_instr || acc_wr || acc_rd;  // RQ1

   // input holding entry: the byte on the bus just before the strobe fell
   assign in_cmd = '{op:   acc_instr ? LSD_OP_INSTR : (acc_wr ? LSD_OP_WRITE : LSD_OP_READ),
                     data: pq.db};  // RQ3

   // FIFO_DEPTH-entry queue (two by default) between the host and the memory sequencer
   assign push_ready  = cnt != (PW + 1)'(FIFO_DEPTH);
   assign pop_valid   = cnt != '0;
   assign head        = fifo_mem[rd_ptr];
   assign o_cmd_ready = push_ready;

   always_ff @(posedge i_clk) begin
      if (push_valid && push_ready) begin
         fifo_mem[wr_ptr] <= in_cmd;  // RQ3
      end
   end

   // a push into a full queue is dropped; the host must honour busy
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         cnt    <= '0;
      end else begin
         if (push_valid && push_ready) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop_valid && pop_ready) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         cnt <= cnt + (PW + 1)'(push_valid && push_ready) - (PW + 1)'(pop_valid && pop_ready);
      end
   end

   // internal operation: memory access on phase one, completion on phase two
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         exec_st <= LSD_EXEC_IDLE;
      end else begin
         case (exec_st)
            LSD_EXEC_IDLE: begin
               if (pop_valid && p1_rise) begin
                  exec_st <= LSD_EXEC_RUN;
               end
            end
            LSD_EXEC_RUN: begin
               if (p2_rise) begin
                  exec_st <= LSD_EXEC_IDLE;
               end
            end
            default: exec_st <= LSD_EXEC_IDLE;
         endcase
      end
   end

   assign pop_ready = (exec_st == LSD_EXEC_RUN) && p2_rise;
   assign instr_do  = pop_ready && pop_valid && head.op == LSD_OP_INSTR;
   assign data_do   = pop_ready && pop_valid && head.op != LSD_OP_INSTR;
   assign ram_we    = (exec_st == LSD_EXEC_IDLE) && pop_valid && p1_rise
                      && head.op == LSD_OP_WRITE;  // RQ3

   // address is {page, column}: eight pages of sixty-four bytes
   lsd_ram #(
      .AW (`LSD_RAM_AW),
      .DW (8)
   ) u_ram (
      .i_clk     (i_clk),
      .i_we      (ram_we),
      .i_addr_a  ({page, col}),  // RQ26
      .i_wdata   (head.data),
      .o_rdata_a (rdata_a),
      .i_addr_b  ({fetched_line[`LSD_F_LPAGE], scan_col}),  // RQ26
      .o_rdata_b (rdata_b)
   );

   // output register: loaded by a data read, shown on the next one
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         out_reg <= `LSD_DB_RST;
      end else if (data_do && head.op == LSD_OP_READ) begin
         out_reg <= rdata_a;  // RQ4
      end
   end

   // column counter: loaded by instruction, stepped by data access, wraps
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         col <= `LSD_COL_RST;
      end else if (instr_do && head.data[`LSD_F_TOP2] == `LSD_OPC_ADDR) begin
         col <= head.data[`LSD_F_COLARG];  // RQ19
      end else if (data_do) begin
         col <= col + 1'b1;  // RQ14 RQ27
      end
   end

   // page register has no count function
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         page <= `LSD_PAGE_RST;
      end else if (instr_do && head.data[`LSD_F_PAGEOP] == `LSD_OPC_PAGE) begin  // RQ13
         page <= head.data[`LSD_F_PAGEARG];  // RQ20
      end
   end

   // reset pin acts whatever the selects show
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         start_line <= `LSD_LINE_RST;
      end else if (rst_pin) begin
         start_line <= `LSD_LINE_RST;  // RQ7
      end else if (instr_do && head.data[`LSD_F_TOP2] == `LSD_OPC_LINE) begin
         start_line <= head.data[`LSD_F_LINEARG];  // RQ21
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         disp_on <= 1'b0;
      end else if (rst_pin) begin
         disp_on <= 1'b0;  // RQ2
      end else if (instr_do && head.data[`LSD_F_ONOFF] == `LSD_OPC_ONOFF) begin
         disp_on <= head.data[`LSD_B_ONOFF];  // RQ18
      end
   end

   // status byte; bit five high means display off
   always_comb begin
      status                = '0;
      status[`LSD_ST_BUSY]  = pop_valid;  // RQ9
      status[`LSD_ST_ONOFF] = !disp_on;  // RQ10
      status[`LSD_ST_RESET] = rst_pin;  // RQ8
   end

   // bus data follow the select line so they are ready as the strobe rises
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_db <= `LSD_DB_RST;
      end else begin
         o_db <= pf.rs ? out_reg : status;  // RQ5
      end
   end

   assign o_db_oe_n = !(sel && pf.strobe && pf.rd);  // RQ23

   // line counter: frame sync presets it, line latch fall advances it
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         line <= `LSD_LINE_RST;
      end else if (pf.frame) begin
         line <= start_line;  // RQ17
      end else if (cl_fall) begin
         line <= line + 1'b1;  // RQ25
      end
   end

   assign o_line = line;

   // fetch the new row into the shadow whenever the line counter moves
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         scan_st      <= LSD_SCAN_IDLE;
         scan_col     <= '0;
         fetched_line <= `LSD_LINE_RST;
      end else begin
         case (scan_st)
            LSD_SCAN_IDLE: begin
               if (fetched_line != line) begin
                  scan_st      <= LSD_SCAN_RUN;
                  scan_col     <= '0;
                  fetched_line <= line;
               end
            end
            LSD_SCAN_RUN: begin
               scan_col <= scan_col + 1'b1;
               if (scan_col == `LSD_COL_W'(`LSD_NCOL - 1)) begin
                  scan_st <= LSD_SCAN_IDLE;
               end
            end
            default: scan_st <= LSD_SCAN_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         scan_rd_q  <= 1'b0;
         scan_col_q <= '0;
      end else begin
         scan_rd_q  <= scan_st == LSD_SCAN_RUN;
         scan_col_q <= scan_col;
      end
   end

   // column order strap: high maps column 0 to segment 0, low reverses
   assign seg_idx = pf.col_order ? scan_col_q : ~scan_col_q;  // RQ16

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         shadow <= '0;
      end else if (scan_rd_q) begin
         shadow[seg_idx] <= rdata_b[fetched_line[`LSD_F_LROW]];  // RQ15
      end
   end

   // row and on/off state take effect together at the line latch rise
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         seg_latch  <= '0;
         disp_shown <= 1'b0;
      end else if (cl_rise) begin
         seg_latch  <= shadow;  // RQ24
         disp_shown <= disp_on;  // RQ12
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_seg <= '0;
      end else begin
         o_seg <= (disp_shown && !rst_pin) ? seg_latch : '0;  // RQ11
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   AST_NOSEL_IGNORED: assert property (  // RQ1
      (strobe_fall && !sel_q) |=> cnt <= $past(cnt))
      else $error("unselected access changed the queue");
   AST_RESET_PIN: assert property (  // RQ7
      rst_pin |=> (!disp_on && start_line == `LSD_LINE_RST))
      else $error("reset pin did not clear on/off and start line");
   AST_WRITE_QUEUED: assert property (  // RQ3
      (acc_wr && push_ready && !pop_ready) |=> cnt == $past(cnt) + 1'b1)
      else $error("write byte not captured");
   AST_STATUS_BUSY: assert property (  // RQ9
      stat_rd ##1 stat_rd |-> o_db[`LSD_ST_BUSY] == $past(pop_valid))
      else $error("busy bit wrong");
   AST_STATUS_RESET: assert property (  // RQ8
      stat_rd ##1 stat_rd |-> o_db[`LSD_ST_RESET] == $past(rst_pin))
      else $error("reset bit wrong");
   AST_STATUS_ONOFF: assert property (  // RQ10
      stat_rd ##1 stat_rd |-> o_db[`LSD_ST_ONOFF] == !$past(disp_on))
      else $error("on/off bit wrong");
   AST_PAGE_HOLD: assert property (  // RQ13
      !instr_do |=> $stable(page))
      else $error("page changed without instruction");
   AST_COL_STEP: assert property (  // RQ14
      data_do |=> col == $past(col) + 1'b1)
      else $error("column did not step");
   AST_OE_STROBE: assert property (  // RQ23
      !pf.strobe |-> o_db_oe_n)
      else $error("bus driven with strobe low");
   AST_ONOFF_AT_CL: assert property (  // RQ12
      !cl_rise |=> $stable(disp_shown))
      else $error("on/off applied off the line latch");
   AST_BLANK_OFF: assert property (  // RQ11
      (!disp_shown || rst_pin) |=> o_seg == '0)
      else $error("segments not blanked");
   AST_LINE_PRESET: assert property (  // RQ17
      pf.frame |=> line == $past(start_line))
      else $error("line counter not preset");

   COV_STATUS: cover property (stat_rd ##1 stat_rd);
   COV_WRITE: cover property (ram_we);
   COV_READ: cover property (data_do && head.op == LSD_OP_READ);
   COV_SCROLL: cover property (pf.frame && start_line != `LSD_LINE_RST);

endmodule

//--- hdl/lsd_pkg.sv
// types shared by the lcd segment driver host port
package lsd_pkg;

   // kinds of queued host access
   typedef enum logic [1:0] {
      LSD_OP_INSTR,
      LSD_OP_WRITE,
      LSD_OP_READ
   } lsd_op_e;

   // one queued host access
   typedef struct packed {
      lsd_op_e    op;
      logic [7:0] data;
   } lsd_cmd_s;

   // all pins that cross into the clock domain
   typedef struct packed {
      logic [7:0] db;
      logic       strobe;
      logic       rd;
      logic       rs;
      logic       cs_a_n;
      logic       cs_b_n;
      logic       cs_h;
      logic       rst_n;
      logic       col_order;
      logic       frame;
      logic       cl;
      logic       p1;
      logic       p2;
   } lsd_pins_s;

   // internal operation sequencer
   typedef enum logic {
      LSD_EXEC_IDLE,
      LSD_EXEC_RUN
   } lsd_exec_e;

   // row fetch for the segment latch
   typedef enum logic {
      LSD_SCAN_IDLE,
      LSD_SCAN_RUN
   } lsd_scan_e;

endpackage

//--- hdl/lsd_ram.sv
// display memory: one write port, two registered read ports
module lsd_ram #(
   parameter int AW = 9,
   parameter int DW = 8
) (
   // clock
   input  wire logic          i_clk,
   // host port: write and read
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_addr_a,
   input  wire logic [DW-1:0] i_wdata,
   output logic      [DW-1:0] o_rdata_a,
   // display scan read
   input  wire logic [AW-1:0] i_addr_b,
   output logic      [DW-1:0] o_rdata_b
);

   if (AW < 1 || DW < 1) begin : g_bad_size
      $error("lsd_ram needs positive widths");
   end

   logic [DW-1:0] mem [2**AW];

   // read during write on port a returns the old byte
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr_a] <= i_wdata;
      end
      o_rdata_a <= mem[i_addr_a];
      o_rdata_b <= mem[i_addr_b];
   end

endmodule

//--- tb/lsd_host_port_bench.sv
// self-checking bench of the lcd segment driver host port
`include "lsd_consts.svh"
module lsd_host_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, resetn, cs_a_n, cs_b_n, cs_h, strobe, rnw, rs, rst_pin, col_order;
   logic        oe_n, ready, p1, p2, frame, cl, oe_prev;
   logic [7:0]  db_in, db_out, last, held;
   logic [63:0] seg, e;
   logic [5:0]  line;
   logic [31:0] seed;
   logic [8:0]  expq[$];
   logic [7:0]  m[64];
   int          err_total, compares;

   lsd_host_port #(.FIFO_DEPTH(2)) lsd_host_port_i (
      .i_clk(clk), .i_resetn(resetn), .i_chip_sel_low_a_n(cs_a_n),
      .i_chip_sel_low_b_n(cs_b_n), .i_chip_sel_high(cs_h), .i_strobe(strobe),
      .i_read_not_write(rnw), .i_data_instr_select(rs), .i_db(db_in), .o_db(db_out),
      .o_db_oe_n(oe_n), .o_cmd_ready(ready), .i_reset_n_pin(rst_pin),
      .i_col_order(col_order), .i_phase_one_clock(p1), .i_phase_two_clock(p2),
      .i_frame_sync(frame), .i_line_latch_strobe(cl), .o_seg(seg), .o_line(line));
   lsd_timing_model lsd_timing_model_i (
      .i_clk(clk), .o_p1(p1), .o_p2(p2), .o_frame(frame), .o_cl(cl));

   always #12.5 clk = ~clk;

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic [7:0] rnd;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   // one host access; a read notes its expected result (bit 8 set: not compared)
   task automatic acc(input logic [2:0] sel, input logic r_s, input logic rd,
                      input logic [7:0] dv, input logic [8:0] exp);
      logic [7:0] r;
      @(negedge clk);
      {cs_a_n, cs_b_n, cs_h} = sel;
      strobe = 1'b0;
      rs = r_s;
      rnw = rd;
      db_in = dv;
      if (sel == 3'b001 && rd) expq.push_back(exp);
      repeat (6) @(negedge clk);
      strobe = 1'b1;
      repeat (6) @(negedge clk);
      check("bus enable", oe_n, !(sel == 3'b001 && rd));
      repeat (4) @(negedge clk);
      last = db_out;
      strobe = 1'b0;
      repeat (6) @(negedge clk);
      // deselected: random noise on every host pin, which the device must ignore
      r = rnd();
      {cs_a_n, cs_b_n, cs_h} = (r[5:3] == 3'b001) ? 3'b110 : r[5:3];
      {strobe, rs, rnw} = r[2:0];
      db_in = rnd();
      check("bus released", oe_n, 1'b1);
   endtask

   // host waits for busy low before the next access
   task automatic idle;
      int n;
      n = 0;
      do begin
         acc(3'b001, 1'b0, 1'b1, 8'h00, 9'h100);
         n++;
      end while (last[`LSD_ST_BUSY] !== 1'b0 && n < 40);
      if (last[`LSD_ST_BUSY] !== 1'b0) check("busy wait", 1'b1, 1'b0);
   endtask

   task automatic status(input logic [7:0] v);
      acc(3'b001, 1'b0, 1'b1, 8'h00, {1'b0, v});
   endtask
   task automatic instr(input logic [7:0] v);
      acc(3'b001, 1'b0, 1'b0, v, 9'h100);
      idle();
   endtask
   task automatic dwr(input logic [7:0] v);
      acc(3'b001, 1'b1, 1'b0, v, 9'h100);
      idle();
   endtask
   task automatic drd(input logic [8:0] exp);
      acc(3'b001, 1'b1, 1'b1, 8'h00, exp);
      idle();
   endtask

   // oldest note is compared when the device lets go of the bus
   always @(negedge clk) begin
      if (oe_n === 1'b0) held <= db_out;
      if (oe_n === 1'b1 && oe_prev === 1'b0) begin
         if (expq.size() == 0) check("unnoted read", 1'b1, 1'b0);
         else begin
            if (!expq[0][8]) check("read data", held, {56'h0, expq[0][7:0]});
            void'(expq.pop_front());
         end
      end
      oe_prev <= oe_n;
   end

   initial begin
      {clk, resetn, strobe, rnw, rs, rst_pin, oe_prev} = 7'h01;
      {cs_a_n, cs_b_n, cs_h} = 3'b110;
      db_in = 8'h00;
      col_order = 1'b1;
      seed = 32'h48;
      err_total = 0;
      compares = 0;
      fork
         begin
            repeat (90000) @(posedge clk);
            err_total++;
            give_verdict();
         end
      join_none
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      repeat (8) @(negedge clk);
      status(8'h30);
      rst_pin = 1'b1;
      repeat (10) @(negedge clk);
      status(8'h20);
      // each select missing in turn: the display-on instruction must be ignored
      for (int k = 0; k < 3; k++) begin
         acc(3'b001 ^ (3'b100 >> k), 1'b0, 1'b0, 8'h3f, 9'h100);
         status(8'h20);
      end
      instr(8'h3f);
      status(8'h00);
      instr(8'hbd);
      instr(8'h40);
      // fill page 5; the last write wraps the column to 0
      for (int c = 0; c < 64; c++) begin
         m[c] = rnd();
         dwr(m[c]);
      end
      m[0] = rnd();
      dwr(m[0]);
      instr(8'h7e);
      drd(9'h100);
      drd({1'b0, m[62]});
      drd({1'b0, m[63]});
      drd({1'b0, m[0]});
      // a write left unwaited must show busy on the next status read
      m[2] = rnd();
      acc(3'b001, 1'b1, 1'b0, m[2], 9'h100);
      m[3] = rnd();
      acc(3'b001, 1'b1, 1'b0, m[3], 9'h100);
      check("queue full", ready, 1'b0);
      status(8'h80);
      idle();
      check("queue free", ready, 1'b1);
      instr(8'he8);
      lsd_timing_model_i.line_pulse(1'b1);
      check("line preset", line, 6'h28);
      lsd_timing_model_i.line_pulse(1'b0);
      check("line step", line, 6'h29);
      for (int c = 0; c < 64; c++) e[c] = m[c][0];
      check("segments", seg, e);
      col_order = 1'b0;
      lsd_timing_model_i.line_pulse(1'b1);
      lsd_timing_model_i.line_pulse(1'b0);
      for (int c = 0; c < 64; c++) e[63-c] = m[c][0];
      check("reversed segments", seg, e);
      instr(8'h3e);
      check("segments before latch", seg, e);
      status(8'h20);
      lsd_timing_model_i.line_pulse(1'b0);
      check("segments off", seg, 64'h0);
      instr(8'h3f);
      lsd_timing_model_i.line_pulse(1'b1);
      rst_pin = 1'b0;
      repeat (10) @(negedge clk);
      check("segments in reset", seg, 64'h0);
      status(8'h30);
      rst_pin = 1'b1;
      repeat (10) @(negedge clk);
      status(8'h20);
      lsd_timing_model_i.line_pulse(1'b1);
      check("start line after reset", line, 6'h00);
      give_verdict();
   end
endmodule

//--- tb/lsd_timing_model.sv
// far-side timing source: two-phase clocks, line latch strobe and frame sync
module lsd_timing_model (
   // clock
   input  wire logic i_clk,
   // timing outputs
   output logic      o_p1,
   output logic      o_p2,
   output logic      o_frame,
   output logic      o_cl
);
   timeunit 1ns;
   timeprecision 100ps;
   int ph = 0;
   initial begin
      o_p1 = 1'b0;
      o_p2 = 1'b0;
      o_frame = 1'b0;
      o_cl = 1'b0;
   end
   // non-overlapping phases, slow so that busy stays visible for many cycles
   always @(negedge i_clk) begin
      ph <= (ph + 1) % 200;
      o_p1 <= (ph < 50);
      o_p2 <= (ph >= 100 && ph < 150);
   end
   // one line period; frame is held over the latch fall so the preset wins there
   task automatic line_pulse(input logic frame_sync);
      @(negedge i_clk) o_frame <= frame_sync;
      repeat (10) @(negedge i_clk);
      o_cl <= 1'b1;
      repeat (100) @(negedge i_clk);
      o_cl <= 1'b0;
      repeat (100) @(negedge i_clk);
      o_frame <= 1'b0;
      repeat (6) @(negedge i_clk);
   endtask
endmodule
